/* nvmc_ctrl.sv */
// top: control register, state decode and gating for the byte array
`timescale 1ns/1ps
`default_nettype none
module nvmc_ctrl
  import nvmc_pkg::*;
#(
  parameter int DEPTH = NVMC_ARRAY_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic        i_stop,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  output logic             o_access_fail,
  output logic             o_high_voltage_pump_pin,
  output logic             o_bus_clock_output_enable,
  output logic             o_upper_array_protect,
  output logic [2:0]       o_state
);
  localparam int AW = $clog2(DEPTH);

  // control register fields and capture state
  logic        clkout_reg, clkout_next;
  logic        erase_select_reg, erase_select_next;
  logic        latch_enable_reg, latch_enable_next;
  logic        pump_enable_reg, pump_enable_next;
  logic        captured_reg, captured_next;
  logic [AW-1:0] cap_addr_reg, cap_addr_next;
  logic [7:0]  cap_data_reg, cap_data_next;
  logic        protect_reg, protect_next;
  logic        opt_loaded_reg, opt_loaded_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic        fail_reg, fail_next;
  nvmc_state_t state_reg, state_next;

  logic          hit_array;
  logic          hit_ctrl;
  logic          busy;
  logic          cap_protected;
  logic          do_prog;
  logic          do_erase;
  logic [AW-1:0] cell_addr;
  logic [7:0]    cell_data;
  logic [7:0]    ctrl_read;

  // address decode of the array window and the control register
  assign hit_array = (i_addr >= NVMC_ARRAY_BASE) &&
                     (i_addr <= NVMC_ARRAY_LAST);
  assign hit_ctrl  = (i_addr == NVMC_CTRL_ADDR);
  assign busy      = latch_enable_reg && pump_enable_reg;

  // upper part protected unless the option bit is one
  assign cap_protected = !protect_reg &&
    ({8'h01, cap_addr_reg} >= NVMC_PROTECT_BASE);

  // the pump acts on the cell only while it is on; no timer
  // erase only ever reaches the one captured byte: no bulk or row path
  assign do_erase = busy && erase_select_reg && captured_reg &&
                    !cap_protected;
  assign do_prog  = busy && !erase_select_reg && captured_reg &&
                    !cap_protected;

  // option slot forced while the protect option loads, so the bus
  // address at reset release cannot pick the wrong byte; then the
  // latched address drives the array while latched and captured, else bus address
  assign cell_addr = !opt_loaded_reg ? NVMC_OPTION_ADDR[AW-1:0] :
                     (latch_enable_reg && captured_reg) ? cap_addr_reg
                                                        : i_addr[AW-1:0];

  nvmc_cell_array #(
    .DEPTH (DEPTH)
  ) u_cells (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_addr  (cell_addr),
    .i_prog  (do_prog),
    .i_erase (do_erase),
    .i_data  (cap_data_reg),
    .o_data  (cell_data)
  );

  // control readback with upper nibble zero
  assign ctrl_read = {4'h0, clkout_reg, erase_select_reg,
                      latch_enable_reg, pump_enable_reg};

  // next-state logic for the control register and capture
  always_comb begin
    clkout_next       = clkout_reg;
    erase_select_next = erase_select_reg;
    latch_enable_next = latch_enable_reg;
    pump_enable_next  = pump_enable_reg;
    captured_next     = captured_reg;
    cap_addr_next     = cap_addr_reg;
    cap_data_next     = cap_data_reg;
    if (i_wr && hit_ctrl) begin
      clkout_next       = i_wdata[NVMC_BIT_CLKOUT];
      latch_enable_next = i_wdata[NVMC_BIT_LATCH];
      if (!captured_reg) begin
        erase_select_next = i_wdata[NVMC_BIT_ERASE];
      end
      if (captured_reg && i_wdata[NVMC_BIT_PUMP]) begin
        pump_enable_next = 1'b1;
      end
    end else if (i_wr && hit_array && latch_enable_reg &&
                 !pump_enable_reg && !captured_reg) begin
      // first array write captures; later ones are ignored
      captured_next = 1'b1;
      cap_addr_next = i_addr[AW-1:0];
      cap_data_next = erase_select_reg ? NVMC_ERASED_BYTE
                                       : i_wdata;
    end
    // unlatched: everything tied to the operation collapses
    if (!latch_enable_next) begin
      erase_select_next = 1'b0;
      pump_enable_next  = 1'b0;
      captured_next     = 1'b0;
    end
    if (i_stop) begin
      latch_enable_next = 1'b0;
      erase_select_next = 1'b0;
      pump_enable_next  = 1'b0;
      captured_next     = 1'b0;
    end
  end

  // state decode of erase/latch/pump into five conditions
  always_comb begin
    unique case ({erase_select_next, latch_enable_next,
                  pump_enable_next})
      3'b010:  state_next = NVMC_ST_LOAD;
      3'b011:  state_next = NVMC_ST_PROG;
      3'b110:  state_next = NVMC_ST_ERASE_LOAD;
      3'b111:  state_next = NVMC_ST_ERASE;
      default: state_next = NVMC_ST_READ; // 000 is read; 001, 100 and 101 cannot arise
    endcase
  end

  // read path: registered answer one cycle after the strobe
  always_comb begin
    rdata_next  = 8'h00;
    rvalid_next = 1'b0;
    fail_next   = 1'b0;
    if ((i_rd || i_wr) && hit_array && busy) begin
      fail_next = 1'b1;
    end else if (i_rd && hit_array) begin
      rvalid_next = 1'b1;
      rdata_next  = latch_enable_reg ? NVMC_ERASED_BYTE
                                     : cell_data;
    end else if (i_rd && hit_ctrl) begin
      rvalid_next = 1'b1;
      rdata_next  = ctrl_read;
    end
  end

  // protect option latched from the option byte after reset release
  always_comb begin
    protect_next    = protect_reg;
    opt_loaded_next = 1'b1;
    if (!opt_loaded_reg) begin
      protect_next = cell_data[NVMC_BIT_PROTECT];
    end
  end

  // register stage for all state
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clkout_reg       <= NVMC_CTRL_RESET[NVMC_BIT_CLKOUT];
      erase_select_reg <= NVMC_CTRL_RESET[NVMC_BIT_ERASE];
      latch_enable_reg <= NVMC_CTRL_RESET[NVMC_BIT_LATCH];
      pump_enable_reg  <= NVMC_CTRL_RESET[NVMC_BIT_PUMP];
      captured_reg     <= 1'b0;
      cap_addr_reg     <= '0;
      cap_data_reg     <= 8'h00;
      protect_reg      <= NVMC_OPTION_RESET[NVMC_BIT_PROTECT];
      opt_loaded_reg   <= 1'b0;
      rdata_reg        <= 8'h00;
      rvalid_reg       <= 1'b0;
      fail_reg         <= 1'b0;
      state_reg        <= NVMC_ST_READ;
    end else if (i_ce) begin
      clkout_reg       <= clkout_next;
      erase_select_reg <= erase_select_next;
      latch_enable_reg <= latch_enable_next;
      pump_enable_reg  <= pump_enable_next;
      captured_reg     <= captured_next;
      cap_addr_reg     <= cap_addr_next;
      cap_data_reg     <= cap_data_next;
      protect_reg      <= protect_next;
      opt_loaded_reg   <= opt_loaded_next;
      rdata_reg        <= rdata_next;
      rvalid_reg       <= rvalid_next;
      fail_reg         <= fail_next;
      state_reg        <= state_next;
    end
  end

  // every output straight from a flip-flop
  assign o_rdata                   = rdata_reg;
  assign o_rvalid                  = rvalid_reg;
  assign o_access_fail             = fail_reg;
  assign o_high_voltage_pump_pin   = pump_enable_reg;
  assign o_bus_clock_output_enable = clkout_reg;
  assign o_upper_array_protect     = protect_reg;
  assign o_state                   = state_reg;
endmodule
`default_nettype wire

/* nvmc_pkg.sv */
// package: constants for the byte-erasable nonvolatile array controller
package nvmc_pkg;
  localparam logic [15:0] NVMC_ARRAY_BASE    = 16'h0100;
  localparam logic [15:0] NVMC_ARRAY_LAST    = 16'h01ff;
  localparam logic [15:0] NVMC_PROTECT_BASE  = 16'h0120;
  localparam logic [15:0] NVMC_OPTION_ADDR   = 16'h0100;
  localparam logic [15:0] NVMC_CTRL_ADDR     = 16'h0007;
  localparam int          NVMC_ARRAY_DEPTH   = 256;
  localparam int          NVMC_BIT_CLKOUT    = 3;
  localparam int          NVMC_BIT_ERASE     = 2;
  localparam int          NVMC_BIT_LATCH     = 1;
  localparam int          NVMC_BIT_PUMP      = 0;
  localparam int          NVMC_BIT_PROTECT   = 1;
  localparam logic [7:0]  NVMC_CTRL_RESET    = 8'h00;
  localparam logic [7:0]  NVMC_ERASED_BYTE   = 8'hff;
  localparam logic [7:0]  NVMC_OPTION_RESET  = 8'hff;
  typedef enum logic [2:0] {
    NVMC_ST_READ,
    NVMC_ST_LOAD,
    NVMC_ST_PROG,
    NVMC_ST_ERASE_LOAD,
    NVMC_ST_ERASE
  } nvmc_state_t;
endpackage

/* nvmc_cell_array.sv */
// byte array storage: erase sets all ones, program clears bits
`timescale 1ns/1ps
`default_nettype none
module nvmc_cell_array
  import nvmc_pkg::*;
#(
  parameter int DEPTH = NVMC_ARRAY_DEPTH
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_ce,
  input  wire logic [$clog2(DEPTH)-1:0] i_addr,
  input  wire logic                     i_prog,
  input  wire logic                     i_erase,
  input  wire logic [7:0]               i_data,
  output var  logic [7:0]               o_data
);
  logic [7:0] mem [DEPTH];

  // no reset: contents are nonvolatile; erased image at start
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = NVMC_ERASED_BYTE;
    end
  end

  // programming only moves bits toward zero, erase restores ones
  always_ff @(posedge i_clk) begin
    if (i_ce && i_erase) begin
      mem[i_addr] <= NVMC_ERASED_BYTE;
    end else if (i_ce && i_prog) begin
      mem[i_addr] <= mem[i_addr] & i_data;
    end
  end

  assign o_data = mem[i_addr];
endmodule
`default_nettype wire

/* nvmc_ctrl_props.sv */
// checker: port timing relations of the array controller
`timescale 1ns/1ps
`default_nettype none
module nvmc_ctrl_props
  import nvmc_pkg::*;
#(
  parameter int DEPTH = NVMC_ARRAY_DEPTH
) (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_ce,
  input wire logic        i_stop,
  input wire logic [15:0] i_addr,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_rvalid,
  input wire logic        o_access_fail,
  input wire logic        o_high_voltage_pump_pin,
  input wire logic        o_bus_clock_output_enable,
  input wire logic        o_upper_array_protect,
  input wire logic [2:0]  o_state
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic arr;
  logic busy;
  logic lat;
  // decoded views of the address and the operating state
  assign arr  = i_addr[15:8] == 8'h01;
  assign busy = o_state == NVMC_ST_PROG || o_state == NVMC_ST_ERASE;
  assign lat  = o_state == NVMC_ST_LOAD || o_state == NVMC_ST_ERASE_LOAD;
  AST_BUSY_FAIL: assert property (i_ce && i_rd && arr && busy
    |=> o_access_fail && !o_rvalid) else $error("busy read not refused");
  AST_IDLE_FAIL: assert property (o_access_fail |-> $past(busy))
    else $error("fail pulse while idle");
  AST_LATCH_FF: assert property (i_ce && i_rd && arr && lat
    |=> o_rvalid && o_rdata == 8'hff) else $error("latched read not ff");
  AST_PUMP_PIN: assert property (o_high_voltage_pump_pin == busy)
    else $error("pump pin disagrees with state");
  AST_STATE_CODE: assert property (o_state <= 3'h4)
    else $error("illegal state code");
  AST_STOP: assert property (i_ce && i_stop |=> o_state == NVMC_ST_READ)
    else $error("stop did not return to read");
  AST_HOLD: assert property (busy && !i_stop && !(i_wr
    && i_addr == NVMC_CTRL_ADDR && !i_wdata[NVMC_BIT_LATCH])
    |=> $stable(o_state)) else $error("operation ended early");
  AST_PATH: assert property ($changed(o_state) && busy
    |-> $past(o_state) == o_state - 3'h1) else $error("bad busy entry");
  AST_UNMAPPED: assert property (i_ce && i_rd && !arr
    && i_addr != NVMC_CTRL_ADDR |=> !o_rvalid) else $error("unmapped rvalid");
  // main scenarios reached
  C_ERASE: cover property (o_state == NVMC_ST_ERASE);
  C_END: cover property (busy ##1 o_state == NVMC_ST_READ);
  C_FAIL: cover property (o_access_fail);
endmodule
bind nvmc_ctrl nvmc_ctrl_props #(.DEPTH(DEPTH)) u_props (
  .i_clk                     (i_clk),
  .i_sys_rst                 (i_sys_rst),
  .i_ce                      (i_ce),
  .i_stop                    (i_stop),
  .i_addr                    (i_addr),
  .i_rd                      (i_rd),
  .i_wr                      (i_wr),
  .i_wdata                   (i_wdata),
  .o_rdata                   (o_rdata),
  .o_rvalid                  (o_rvalid),
  .o_access_fail             (o_access_fail),
  .o_high_voltage_pump_pin   (o_high_voltage_pump_pin),
  .o_bus_clock_output_enable (o_bus_clock_output_enable),
  .o_upper_array_protect     (o_upper_array_protect),
  .o_state                   (o_state)
);
`default_nettype wire

/* nvmc_cpu_model.sv */
// partner: cpu bus master making one-cycle register and array accesses
`timescale 1ns/1ps
`default_nettype none
module nvmc_cpu_model
  import nvmc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_rdata,
  input  wire logic        i_rvalid,
  input  wire logic        i_fail,
  output logic      [15:0] o_addr,
  output logic             o_rd,
  output logic             o_wr,
  output logic      [7:0]  o_wdata
);
  // parked on the option byte so the load after reset sees it
  initial begin
    o_addr = NVMC_OPTION_ADDR;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  // code never runs from the array, it is only a data target
  task automatic access(input logic w, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic v,
      output logic f);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wr = w;
    o_rd = !w;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = NVMC_OPTION_ADDR;
    o_wdata = ~d;  // released data must not hold the old value
    q = i_rdata;
    v = i_rvalid;
    f = i_fail;
  endtask
endmodule
`default_nettype wire

/* tb_nvmc_ctrl.sv */
// testbench: row-driven program and erase sequences plus reset cases
`timescale 1ns/1ps
`default_nettype none
module tb_nvmc_ctrl;
  import nvmc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_ce = 1'b1;
  logic        i_stop = 1'b0;
  logic [15:0] addr;
  logic        rd, wr, rvalid, fail, pump, clko, prot;
  logic [7:0]  wdata, rdata;
  logic [2:0]  state;
  int          bad_count = 0;
  int          n_checks = 0;
  // rows: op (0 write, 1 read, 2 read checked for valid and fail, 3 stop, 4 pump and
  // state), addr, data, exp
  logic [35:0] rows [45] = '{
    36'h0_0007_02_00, 36'h1_0007_00_02, 36'h1_0105_00_ff,
    36'h0_0007_03_00, 36'h1_0007_00_02, 36'h0_0105_00_00,
    36'h0_0106_00_00, 36'h0_0007_03_00, 36'h4_0000_00_0a,
    36'h2_0105_00_01, 36'h0_0007_02_00, 36'h1_0007_00_03,
    36'h0_0007_00_00, 36'h1_0105_00_00, 36'h1_0106_00_ff,
    36'h0_0007_06_00, 36'h0_0105_55_00, 36'h0_0007_03_00,
    36'h4_0000_00_0c, 36'h1_0007_00_07, 36'h0_0007_00_00,
    36'h1_0105_00_ff, 36'h0_0007_fd_00, 36'h1_0007_00_08,
    36'h0_0007_02_00, 36'h3_0000_00_00, 36'h1_0007_00_00,
    36'h2_0050_00_00, 36'h0_0007_02_00, 36'h0_0100_fd_00,
    36'h0_0007_03_00, 36'h0_0007_00_00, 36'h1_0100_00_fd,
    36'h0_0007_0a_00, 36'h1_0007_00_00, 36'h0_0007_02_00,
    36'h0_0120_00_00, 36'h0_0007_03_00, 36'h0_0007_00_00,
    36'h1_0120_00_ff, 36'h0_0007_02_00, 36'h0_011f_00_00,
    36'h0_0007_03_00, 36'h0_0007_00_00, 36'h1_011f_00_00};
  always #2 i_clk = ~i_clk;
  nvmc_ctrl uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_stop(i_stop), .i_addr(addr), .i_rd(rd), .i_wr(wr),
    .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_access_fail(fail), .o_high_voltage_pump_pin(pump),
    .o_bus_clock_output_enable(clko), .o_upper_array_protect(prot),
    .o_state(state));
  nvmc_cpu_model cpu (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .i_fail(fail), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // release lands off the edge; the next edge loads the protect option,
  // so outputs are looked at 1 ns after it, once they have settled
  task automatic do_reset();
    i_sys_rst = 1'b1;
    repeat (12) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic run(input int lo, input int hi);
    logic [7:0] q;
    logic       v, f;
    for (int k = lo; k <= hi; k++) begin
      if (rows[k][35:32] == 4'h3) begin
        @(posedge i_clk);
        #1;
        i_stop = 1'b1;
        @(posedge i_clk);
        #1;
        i_stop = 1'b0;
      end else if (rows[k][35:32] == 4'h4) begin
        @(posedge i_clk);
        #1;
        chk({4'h0, pump, state}, rows[k][7:0]);
      end else begin
        cpu.access(rows[k][35:32] == 4'h0, rows[k][31:16], rows[k][15:8],
          q, v, f);
        if (rows[k][35:32] == 4'h1) begin
          chk({7'h00, v}, 8'h01);
          chk(q, rows[k][7:0]);
        end
        if (rows[k][35:32] == 4'h2) chk({6'h00, v, f}, rows[k][7:0]);
      end
    end
  endtask
  // rows first, then a mid-run reset with the protect option cleared,
  // then a control write while the clock enable is low
  initial begin
    logic [7:0] q;
    logic       v, f;
    do_reset();
    chk({2'b00, clko, pump, prot, state}, 8'h08);
    run(0, 33);
    chk({6'h00, clko, prot}, 8'h03);
    do_reset();
    chk({2'b00, clko, pump, prot, state}, 8'h00);
    run(34, 44);
    // frozen state must ignore the write entirely
    i_ce = 1'b0;
    cpu.access(1'b1, NVMC_CTRL_ADDR, 8'h02, q, v, f);
    i_ce = 1'b1;
    cpu.access(1'b0, NVMC_CTRL_ADDR, 8'h00, q, v, f);
    chk({7'h00, v}, 8'h01);
    chk(q, NVMC_CTRL_RESET);
    conclude();
  end
endmodule
`default_nettype wire
